// ==== design/sdr_aux_out.sv ====
/*
  auxiliary output generator: lane-rate derived clock or resampled timestamp.
  assumes ui_tick_i pulses once per serial unit interval as a clock enable.
*/
`timescale 1ns/1ps
module sdr_aux_out (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire sdr_pkg::sdr_aux_cfg_type cfg_i,
  input wire logic ui_tick_i,
  input wire logic ser_reinit_i,
  input wire logic tstamp_i,
  output logic aux_o
);

  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic aux_r;
  logic aux_nxt;
  logic [5:0] half;
  logic ser_mode;

  always_comb begin
    half = 6'h00;
    ser_mode = 1'b1;
    unique case (cfg_i.select)
      sdr_pkg::SDR_AUX_UI16: half = {1'b0, sdr_pkg::UI16_HALF};
      sdr_pkg::SDR_AUX_UI32: half = {1'b0, sdr_pkg::UI32_HALF};
      sdr_pkg::SDR_AUX_UI64: half = sdr_pkg::UI64_HALF;
      default: ser_mode = 1'b0;
    endcase
  end

  always_comb begin
    cnt_nxt = cnt_r;
    aux_nxt = aux_r;
    if (!cfg_i.enable) begin
      cnt_nxt = 6'h00;
      aux_nxt = 1'b0;
    end else if (ser_mode) begin
      if (ser_reinit_i) begin
        cnt_nxt = 6'h00;
        aux_nxt = 1'b0;
      end else if (ui_tick_i) begin
        if (cnt_r >= half - 6'h01) begin
          cnt_nxt = 6'h00;
          aux_nxt = ~aux_r;
        end else begin
          cnt_nxt = cnt_r + 6'h01;
        end
      end
    end else if (cfg_i.select == sdr_pkg::SDR_AUX_TSTAMP) begin
      cnt_nxt = 6'h00;
      aux_nxt = tstamp_i;
    end else begin
      // reserved selects hold the output low
      cnt_nxt = 6'h00;
      aux_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 6'h00;
      aux_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      aux_r <= aux_nxt;
    end
  end

  assign aux_o = aux_r;

endmodule : sdr_aux_out

// ==== design/sdr_pkg.sv ====
/*
  shared constants and types for the synthesizer divider and auxiliary output register bank.
  assumes byte-wide registers reached over a serial register port with 15-bit addresses.
*/
package sdr_pkg;

  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam logic [4:0] FRAME_LAST = 5'h17;
  localparam logic [4:0] ADDR_LAST = 5'h0F;

  localparam logic [14:0] OFS_PRESCALE_POST = 15'h003D;
  localparam logic [14:0] OFS_FB_COUNT = 15'h003E;
  localparam logic [14:0] OFS_OSC_BIAS = 15'h003F;
  localparam logic [14:0] OFS_LANE_EMPH = 15'h0048;
  localparam logic [14:0] OFS_AUX_OUT = 15'h0057;
  localparam logic [14:0] OFS_PIN_OVR = 15'h0058;

  localparam logic [7:0] RST_PRESCALE_POST = 8'h00;
  localparam logic [7:0] RST_FB_COUNT = 8'h20;
  localparam logic [7:0] RST_OSC_BIAS = 8'h4F;
  localparam logic [7:0] RST_LANE_EMPH = 8'h00;
  localparam logic [7:0] RST_AUX_OUT = 8'h00;
  localparam logic [7:0] RST_PIN_OVR = 8'h00;

  localparam logic [6:0] OSC_BIAS_DEFAULT = 7'h4F;
  localparam logic [6:0] OSC_BIAS_IN_USE = 7'h4A;

  localparam int POST_SEL_LSB = 2;
  localparam int PRE_SEL_LSB = 0;
  localparam int FB_COUNT_W = 6;
  localparam int OSC_BIAS_W = 7;
  localparam int EMPH_W = 4;
  localparam int AUX_EN_BIT = 7;
  localparam int AUX_SEL_W = 3;

  localparam logic [2:0] PRE_RATIO_RST = 3'h5;
  localparam logic [2:0] POST_RATIO_RST = 3'h1;
  localparam logic [5:0] FB_COUNT_RST = 6'h20;

  // half periods of the auxiliary clock, in unit intervals
  localparam logic [4:0] UI16_HALF = 5'h08;
  localparam logic [4:0] UI32_HALF = 5'h10;
  localparam logic [5:0] UI64_HALF = 6'h20;

  typedef enum logic [2:0] {
    SDR_AUX_UI16 = 3'h0,
    SDR_AUX_UI32 = 3'h1,
    SDR_AUX_UI64 = 3'h2,
    SDR_AUX_TSTAMP = 3'h3
  } sdr_aux_sel_type;

  typedef struct packed {
    logic enable;
    logic [2:0] select;
  } sdr_aux_cfg_type;

  typedef struct packed {
    logic [2:0] pre;
    logic [2:0] post;
    logic [5:0] count;
  } sdr_ratio_type;

endpackage : sdr_pkg

// ==== design/sdr_regs.sv ====
/*
  synthesizer divider, oscillator bias, lane emphasis and auxiliary output register bank
  with its serial register port.
  assumes serial port pins are synchronous to CORE_CLK_I and the port clock is slower than
  a quarter of it; frame is one read bit (1 = read), 15 address bits, 8 data bits, msb first.
*/
// Notes on behaviour
// - second divider select: 0 div1, 1 div2, 2 div4, 3 reserved; resets div1.
// - first divider select: 0 div5, 1 div4, 2 div3, 3 reserved; resets div5.
// - third divider ratio is the 6-bit field, 1 to 63, reset 32.
// - bias field resets 0x4F; host must program 0x4A when synthesizer used.
// - one 4-bit emphasis setting drives every serial lane alike.
// - auxiliary enable bit 7 enables output buffer and divider; resets clear.
// - auxiliary select: 16, 32, 64 UI clocks, resampled timestamp; 4-7 reserved.
// - selects up to 2 derive from serializer, interrupted on serializer reinit.
`timescale 1ns/1ps
module sdr_regs #(
  parameter int NUM_LANES = 8
) (
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,
  input wire logic SPI_CS_N_I,
  input wire logic SPI_CLK_I,
  input wire logic SPI_DATA_I,
  output logic SPI_DATA_O,
  output logic SPI_DATA_OE_O,
  input wire logic SYNTH_RESET_CTRL_I,
  output sdr_pkg::sdr_ratio_type SYNTH_RATIO_O,
  output logic [6:0] OSC_BIAS_LEVEL_O,
  output logic OSC_BIAS_AT_DEFAULT_O,
  output logic [NUM_LANES*4-1:0] LANE_PREEMPHASIS_O,
  output logic [7:0] SYNTH_PIN_OVERRIDE_O,
  input wire logic UI_TICK_I,
  input wire logic SER_REINIT_I,
  input wire logic TIMESTAMP_INPUT_I,
  output logic AUX_OUTPUT_PIN_O
);

  typedef enum {SPI_IDLE, SPI_ADDR, SPI_DATA} sdr_spi_state_type;

  sdr_spi_state_type state_r, state_nxt;
  logic sclk_d_r, sclk_d_nxt;
  logic [4:0] bit_cnt_r, bit_cnt_nxt;
  logic [15:0] hdr_r, hdr_nxt;
  logic [7:0] wdat_r, wdat_nxt;
  logic [7:0] rdat_r, rdat_nxt;
  logic sdo_r, sdo_nxt;
  logic oe_r, oe_nxt;
  logic wr_stb;
  logic sclk_rise;
  logic sclk_fall;

  logic [7:0] prescale_post_r, prescale_post_nxt;
  logic [7:0] fb_count_r, fb_count_nxt;
  logic [7:0] osc_bias_r, osc_bias_nxt;
  logic [7:0] lane_emph_r, lane_emph_nxt;
  logic [7:0] aux_out_r, aux_out_nxt;
  logic [7:0] pin_ovr_r, pin_ovr_nxt;
  sdr_pkg::sdr_ratio_type ratio_r, ratio_nxt;
  sdr_pkg::sdr_aux_cfg_type aux_cfg;

  // register read mux, sampled once the address is complete
  function automatic logic [7:0] read_reg(input logic [14:0] addr);
    unique case (addr)
      sdr_pkg::OFS_PRESCALE_POST: read_reg = prescale_post_r;
      sdr_pkg::OFS_FB_COUNT: read_reg = fb_count_r;
      sdr_pkg::OFS_OSC_BIAS: read_reg = osc_bias_r;
      sdr_pkg::OFS_LANE_EMPH: read_reg = lane_emph_r;
      sdr_pkg::OFS_AUX_OUT: read_reg = aux_out_r;
      sdr_pkg::OFS_PIN_OVR: read_reg = pin_ovr_r;
      default: read_reg = 8'h00;
    endcase
  endfunction : read_reg

  function automatic logic [2:0] post_ratio(input logic [1:0] sel, input logic [2:0] prev);
    unique case (sel)
      2'h0: post_ratio = 3'h1;
      2'h1: post_ratio = 3'h2;
      2'h2: post_ratio = 3'h4;
      default: post_ratio = prev;
    endcase
  endfunction : post_ratio

  function automatic logic [2:0] pre_ratio(input logic [1:0] sel, input logic [2:0] prev);
    unique case (sel)
      2'h0: pre_ratio = 3'h5;
      2'h1: pre_ratio = 3'h4;
      2'h2: pre_ratio = 3'h3;
      default: pre_ratio = prev;
    endcase
  endfunction : pre_ratio

  // serial port engine
  assign sclk_rise = SPI_CLK_I & ~sclk_d_r;
  assign sclk_fall = ~SPI_CLK_I & sclk_d_r;

  always_comb begin
    state_nxt = state_r;
    sclk_d_nxt = SPI_CLK_I;
    bit_cnt_nxt = bit_cnt_r;
    hdr_nxt = hdr_r;
    wdat_nxt = wdat_r;
    rdat_nxt = rdat_r;
    sdo_nxt = sdo_r;
    oe_nxt = oe_r;
    wr_stb = 1'b0;
    if (SPI_CS_N_I) begin
      state_nxt = SPI_IDLE;
      oe_nxt = 1'b0;
      sdo_nxt = 1'b0;
    end else begin
      unique case (state_r)
        SPI_IDLE: begin
          bit_cnt_nxt = 5'h00;
          state_nxt = SPI_ADDR;
        end
        SPI_ADDR: begin
          if (sclk_rise) begin
            hdr_nxt = {hdr_r[14:0], SPI_DATA_I};
            bit_cnt_nxt = bit_cnt_r + 5'h01;
            if (bit_cnt_r == sdr_pkg::ADDR_LAST) begin
              state_nxt = SPI_DATA;
              rdat_nxt = read_reg({hdr_r[13:0], SPI_DATA_I});
            end
          end
        end
        SPI_DATA: begin
          if (sclk_fall && hdr_r[15] && bit_cnt_r != 5'h00) begin
            sdo_nxt = rdat_r[7];
            rdat_nxt = {rdat_r[6:0], 1'b0};
            oe_nxt = 1'b1;
          end
          if (sclk_rise) begin
            wdat_nxt = {wdat_r[6:0], SPI_DATA_I};
            bit_cnt_nxt = bit_cnt_r + 5'h01;
            if (bit_cnt_r == sdr_pkg::FRAME_LAST) begin
              wr_stb = ~hdr_r[15];
              state_nxt = SPI_IDLE;
              bit_cnt_nxt = 5'h00;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_r <= SPI_IDLE;
      sclk_d_r <= 1'b0;
      bit_cnt_r <= 5'h00;
      hdr_r <= 16'h0000;
      wdat_r <= 8'h00;
      rdat_r <= 8'h00;
      sdo_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sclk_d_r <= sclk_d_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      hdr_r <= hdr_nxt;
      wdat_r <= wdat_nxt;
      rdat_r <= rdat_nxt;
      sdo_r <= sdo_nxt;
      oe_r <= oe_nxt;
    end
  end

  // register bank; every bit stored as written, reserved bits included
  always_comb begin
    logic [7:0] wval;
    wval = {wdat_r[6:0], SPI_DATA_I};
    prescale_post_nxt = prescale_post_r;
    fb_count_nxt = fb_count_r;
    osc_bias_nxt = osc_bias_r;
    lane_emph_nxt = lane_emph_r;
    aux_out_nxt = aux_out_r;
    pin_ovr_nxt = pin_ovr_r;
    if (wr_stb) begin
      unique case (hdr_r[14:0])
        sdr_pkg::OFS_PRESCALE_POST: prescale_post_nxt = wval;
        sdr_pkg::OFS_FB_COUNT: fb_count_nxt = wval;
        sdr_pkg::OFS_OSC_BIAS: osc_bias_nxt = wval;
        sdr_pkg::OFS_LANE_EMPH: lane_emph_nxt = wval;
        sdr_pkg::OFS_AUX_OUT: aux_out_nxt = wval;
        sdr_pkg::OFS_PIN_OVR: pin_ovr_nxt = wval;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      prescale_post_r <= sdr_pkg::RST_PRESCALE_POST;
      fb_count_r <= sdr_pkg::RST_FB_COUNT;
      osc_bias_r <= sdr_pkg::RST_OSC_BIAS;
      lane_emph_r <= sdr_pkg::RST_LANE_EMPH;
      aux_out_r <= sdr_pkg::RST_AUX_OUT;
      pin_ovr_r <= sdr_pkg::RST_PIN_OVR;
    end else begin
      prescale_post_r <= prescale_post_nxt;
      fb_count_r <= fb_count_nxt;
      osc_bias_r <= osc_bias_nxt;
      lane_emph_r <= lane_emph_nxt;
      aux_out_r <= aux_out_nxt;
      pin_ovr_r <= pin_ovr_nxt;
    end
  end

  // divider ratios; a reserved or unsupported code keeps the last legal ratio
  always_comb begin
    ratio_nxt.post = post_ratio(prescale_post_r[sdr_pkg::POST_SEL_LSB +: 2], ratio_r.post);
    ratio_nxt.pre = pre_ratio(prescale_post_r[sdr_pkg::PRE_SEL_LSB +: 2], ratio_r.pre);
    ratio_nxt.count = ratio_r.count;
    if (fb_count_r[sdr_pkg::FB_COUNT_W-1:0] != 6'h00) begin
      ratio_nxt.count = fb_count_r[sdr_pkg::FB_COUNT_W-1:0];
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ratio_r.pre <= sdr_pkg::PRE_RATIO_RST;
      ratio_r.post <= sdr_pkg::POST_RATIO_RST;
      ratio_r.count <= sdr_pkg::FB_COUNT_RST;
    end else begin
      ratio_r <= ratio_nxt;
    end
  end

  assign SYNTH_RATIO_O = ratio_r;
  assign OSC_BIAS_LEVEL_O = osc_bias_r[sdr_pkg::OSC_BIAS_W-1:0];
  // flags the bias left at default while the synthesizer runs
  assign OSC_BIAS_AT_DEFAULT_O = ~SYNTH_RESET_CTRL_I &
    (osc_bias_r[sdr_pkg::OSC_BIAS_W-1:0] == sdr_pkg::OSC_BIAS_DEFAULT);
  assign SYNTH_PIN_OVERRIDE_O = pin_ovr_r;
  assign SPI_DATA_O = sdo_r;
  assign SPI_DATA_OE_O = oe_r;

  for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
    assign LANE_PREEMPHASIS_O[g*4 +: 4] = lane_emph_r[sdr_pkg::EMPH_W-1:0];
  end

  assign aux_cfg.enable = aux_out_r[sdr_pkg::AUX_EN_BIT];
  assign aux_cfg.select = aux_out_r[sdr_pkg::AUX_SEL_W-1:0];

  sdr_aux_out u_aux (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RESETN_I),
    .cfg_i(aux_cfg),
    .ui_tick_i(UI_TICK_I),
    .ser_reinit_i(SER_REINIT_I),
    .tstamp_i(TIMESTAMP_INPUT_I),
    .aux_o(AUX_OUTPUT_PIN_O)
  );

endmodule : sdr_regs

// ==== tb/sdr_host.sv ====
/*
  host model driving the serial register port.
  assumes pins sampled by the core clock; each serial clock phase lasts 3 core cycles.
*/
`timescale 1ns/1ps
module sdr_host (
  input wire logic clk_i,
  input wire logic sdo_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic sdi_o
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end
  // nbits below 24 cuts the frame: chip select rises after that many bits
  task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] d,
                      input int nbits, output logic [7:0] q);
    logic [23:0] f;
    f = {rd, a, d};
    q = 8'h00;
    @(posedge clk_i);
    #1 cs_n_o = 1'b0;
    for (int i = 23; i >= 24 - nbits; i--) begin
      sclk_o = 1'b0;
      sdi_o = f[i];
      repeat (3) @(posedge clk_i);
      #1 sclk_o = 1'b1;
      if (i < 8) q[i] = sdo_i;
      repeat (3) @(posedge clk_i);
      #1;
    end
    sclk_o = 1'b0;
    sdi_o = ~sdi_o;  // released line shows no stale value
    repeat (3) @(posedge clk_i);
    #1 cs_n_o = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
  endtask : xfer
endmodule : sdr_host

// ==== tb/sdr_regs_props.sv ====
/*
  concurrent checks on the register bank's top-level ports.
  assumes it is bound to sdr_regs and that reset is active low.
*/
`timescale 1ns/1ps
module sdr_regs_props #(
  parameter int NUM_LANES = 8
) (
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,
  input wire logic SPI_CS_N_I,
  input wire logic SPI_DATA_OE_O,
  input wire logic SYNTH_RESET_CTRL_I,
  input wire sdr_pkg::sdr_ratio_type SYNTH_RATIO_O,
  input wire logic [6:0] OSC_BIAS_LEVEL_O,
  input wire logic OSC_BIAS_AT_DEFAULT_O,
  input wire logic [NUM_LANES*4-1:0] LANE_PREEMPHASIS_O,
  input wire logic UI_TICK_I,
  input wire logic SER_REINIT_I,
  input wire logic TIMESTAMP_INPUT_I,
  input wire logic AUX_OUTPUT_PIN_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESETN_I);
  sequence cs_idle;
    SPI_CS_N_I [*2];
  endsequence
  sequence reinit_quiet;
    (SER_REINIT_I && !TIMESTAMP_INPUT_I) [*2];
  endsequence
  chk_oe_release:
  assert property (cs_idle |-> !SPI_DATA_OE_O) else $error("data driven outside frame");
  chk_emph_global:
  assert property (LANE_PREEMPHASIS_O == {NUM_LANES{LANE_PREEMPHASIS_O[3:0]}})
    else $error("lanes differ");
  chk_div_legal:
  assert property (SYNTH_RATIO_O.pre inside {3'h3, 3'h4, 3'h5} &&
    SYNTH_RATIO_O.post inside {3'h1, 3'h2, 3'h4}) else $error("bad divider");
  chk_count_range:
  assert property (SYNTH_RATIO_O.count != 6'h00) else $error("count zero");
  chk_ratio_reset:
  assert property ($rose(RESETN_I) |-> SYNTH_RATIO_O == {3'h5, 3'h1, 6'h20})
    else $error("ratio reset wrong");
  chk_bias_flag:
  assert property (OSC_BIAS_AT_DEFAULT_O ==
    (!SYNTH_RESET_CTRL_I && OSC_BIAS_LEVEL_O == 7'h4F)) else $error("bias flag wrong");
  chk_cfg_quiet:
  assert property ($changed(SYNTH_RATIO_O) || $changed(OSC_BIAS_LEVEL_O) |->
    !$past(SPI_CS_N_I)) else $error("config changed outside frame");
  chk_aux_reinit:
  assert property (reinit_quiet |-> !AUX_OUTPUT_PIN_O) else $error("aux not held");
  chk_aux_cause:
  assert property ($rose(AUX_OUTPUT_PIN_O) |->
    $past(UI_TICK_I) || $past(UI_TICK_I, 2) || $past(TIMESTAMP_INPUT_I))
    else $error("aux rose without cause");
endmodule : sdr_regs_props

// ==== tb/tb.sv ====
/*
  self-checking bench for the divider and auxiliary output register bank.
  assumes the host model sdr_host and the checker sdr_regs_props.
*/
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cs_n, sclk, sdi, sdo, oe, aux, atdef;
  logic rstc = 1'b0;
  logic tick = 1'b0;
  logic reinit = 1'b0;
  logic ts = 1'b0;
  sdr_pkg::sdr_ratio_type ratio;
  logic [6:0] bias;
  logic [31:0] emph;
  logic [7:0] ovr;
  int miscompares = 0;
  int comparisons = 0;
  int tc = 0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    tc = (tc == 2) ? 0 : tc + 1;
    #1 tick = (tc == 0);
  end
  sdr_regs #(.NUM_LANES(8)) i_dut (.CORE_CLK_I(clk), .RESETN_I(rst_n), .SPI_CS_N_I(cs_n),
    .SPI_CLK_I(sclk), .SPI_DATA_I(sdi), .SPI_DATA_O(sdo), .SPI_DATA_OE_O(oe),
    .SYNTH_RESET_CTRL_I(rstc), .SYNTH_RATIO_O(ratio), .OSC_BIAS_LEVEL_O(bias),
    .OSC_BIAS_AT_DEFAULT_O(atdef), .LANE_PREEMPHASIS_O(emph), .SYNTH_PIN_OVERRIDE_O(ovr),
    .UI_TICK_I(tick), .SER_REINIT_I(reinit), .TIMESTAMP_INPUT_I(ts), .AUX_OUTPUT_PIN_O(aux));
  sdr_host i_host (.clk_i(clk), .sdo_i(oe ? sdo : 1'b1), .cs_n_o(cs_n), .sclk_o(sclk),
    .sdi_o(sdi));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] q;
    i_host.xfer(1'b0, a, d, 24, q);
  endtask : wr
  task automatic rchk(input string n, input logic [14:0] a, input logic [7:0] e);
    logic [7:0] q;
    i_host.xfer(1'b1, a, 8'h00, 24, q);
    chk(n, {24'h0, q}, {24'h0, e});
  endtask : rchk
  task automatic t_reset;
    rchk("reg_3d", sdr_pkg::OFS_PRESCALE_POST, 8'h00);
    rchk("reg_3e", sdr_pkg::OFS_FB_COUNT, 8'h20);
    rchk("reg_3f", sdr_pkg::OFS_OSC_BIAS, 8'h4F);
    rchk("reg_48", sdr_pkg::OFS_LANE_EMPH, 8'h00);
    rchk("reg_57", sdr_pkg::OFS_AUX_OUT, 8'h00);
    rchk("reg_58", sdr_pkg::OFS_PIN_OVR, 8'h00);
    rchk("unmapped", 15'h0010, 8'h00);
    chk("ratio", {20'h0, ratio}, {20'h0, 3'h5, 3'h1, 6'h20});
    chk("bias_flag", {31'h0, atdef}, 32'h1);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_div;
    logic [2:0] pre_e [4];
    logic [2:0] post_e [4];
    pre_e = '{3'h5, 3'h4, 3'h3, 3'h3};
    post_e = '{3'h1, 3'h2, 3'h4, 3'h4};
    rstc = 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(sdr_pkg::OFS_PRESCALE_POST, {4'h0, 2'(i), 2'(i)});
      chk("pre", {29'h0, ratio.pre}, {29'h0, pre_e[i]});
      chk("post", {29'h0, ratio.post}, {29'h0, post_e[i]});
    end
    rchk("reg_3d", sdr_pkg::OFS_PRESCALE_POST, 8'h0F);
    wr(sdr_pkg::OFS_FB_COUNT, 8'h01);
    chk("count", {26'h0, ratio.count}, 32'h01);
    wr(sdr_pkg::OFS_FB_COUNT, 8'h3F);
    chk("count", {26'h0, ratio.count}, 32'h3F);
    wr(sdr_pkg::OFS_FB_COUNT, 8'h00);
    chk("count", {26'h0, ratio.count}, 32'h3F);
    rstc = 1'b0;
    $display("t_div done");
  endtask : t_div
  task automatic t_bias_emph;
    wr(sdr_pkg::OFS_OSC_BIAS, 8'h4A);
    chk("bias", {25'h0, bias}, 32'h4A);
    chk("bias_flag", {31'h0, atdef}, 32'h0);
    wr(sdr_pkg::OFS_OSC_BIAS, 8'h4F);
    rstc = 1'b1;
    @(posedge clk);
    #1 chk("bias_flag", {31'h0, atdef}, 32'h0);
    rstc = 1'b0;
    @(posedge clk);
    #1 chk("bias_flag", {31'h0, atdef}, 32'h1);
    wr(sdr_pkg::OFS_OSC_BIAS, 8'h4A);
    chk("bias", {25'h0, bias}, 32'h4A);
    wr(sdr_pkg::OFS_LANE_EMPH, 8'h0A);
    chk("emphasis", emph, {8{4'hA}});
    wr(sdr_pkg::OFS_PIN_OVR, 8'hA5);
    chk("override", {24'h0, ovr}, 32'hA5);
    $display("t_bias_emph done");
  endtask : t_bias_emph
  // cut frames must write nothing and leave the port ready for the next frame
  task automatic t_abort;
    logic [7:0] q;
    i_host.xfer(1'b0, sdr_pkg::OFS_LANE_EMPH, 8'h05, 20, q);
    rchk("reg_48", sdr_pkg::OFS_LANE_EMPH, 8'h0A);
    chk("emphasis", emph, {8{4'hA}});
    i_host.xfer(1'b1, sdr_pkg::OFS_PIN_OVR, 8'h00, 12, q);
    rchk("reg_58", sdr_pkg::OFS_PIN_OVR, 8'hA5);
    $display("t_abort done");
  endtask : t_abort
  task automatic t_midreset;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    chk("ratio", {20'h0, ratio}, {20'h0, 3'h5, 3'h1, 6'h20});
    chk("emphasis", emph, 32'h0);
    chk("bias", {25'h0, bias}, 32'h4F);
    rchk("reg_58", sdr_pkg::OFS_PIN_OVR, 8'h00);
    wr(sdr_pkg::OFS_OSC_BIAS, 8'h4A);
    $display("t_midreset done");
  endtask : t_midreset
  task automatic t_aux;
    int n;
    for (int m = 0; m < 3; m++) begin
      if (m > 0) wr(sdr_pkg::OFS_AUX_OUT, {5'h00, 3'(m - 1)});
      wr(sdr_pkg::OFS_AUX_OUT, {5'h00, 3'(m)});
      wr(sdr_pkg::OFS_AUX_OUT, {5'h10, 3'(m)});
      for (n = 0; n < 300 && aux !== 1'b1; n++) @(negedge clk);
      n = 0;
      while (aux === 1'b1 && n < 100) begin
        @(negedge clk);
        if (tick === 1'b1 && aux === 1'b1) n++;
      end
      chk("aux_half", n, 8 << m);
    end
    @(posedge clk);
    #1 reinit = 1'b1;
    repeat (120) @(posedge clk);
    #1 chk("aux_reinit", {31'h0, aux}, 32'h0);
    reinit = 1'b0;
    wr(sdr_pkg::OFS_AUX_OUT, 8'h02);
    chk("aux_off", {31'h0, aux}, 32'h0);
    wr(sdr_pkg::OFS_AUX_OUT, 8'h03);
    wr(sdr_pkg::OFS_AUX_OUT, 8'h83);
    ts = 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("aux_tstamp", {31'h0, aux}, 32'h1);
    ts = 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("aux_tstamp", {31'h0, aux}, 32'h0);
    wr(sdr_pkg::OFS_AUX_OUT, 8'h03);
    wr(sdr_pkg::OFS_AUX_OUT, 8'h05);
    wr(sdr_pkg::OFS_AUX_OUT, 8'h85);
    repeat (200) @(posedge clk);
    #1 chk("aux_rsv", {31'h0, aux}, 32'h0);
    rchk("reg_57", sdr_pkg::OFS_AUX_OUT, 8'h85);
    $display("t_aux done");
  endtask : t_aux
  task automatic results;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  initial begin
    #300000;
    miscompares++;
    $display("ERROR watchdog expected done seen hang");
    results();
  end
  initial begin
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    t_reset();
    t_div();
    t_bias_emph();
    t_abort();
    t_midreset();
    t_aux();
    results();
  end
endmodule : tb
bind sdr_regs sdr_regs_props #(.NUM_LANES(NUM_LANES)) i_props (.CORE_CLK_I(CORE_CLK_I),
  .RESETN_I(RESETN_I), .SPI_CS_N_I(SPI_CS_N_I), .SPI_DATA_OE_O(SPI_DATA_OE_O),
  .SYNTH_RESET_CTRL_I(SYNTH_RESET_CTRL_I), .SYNTH_RATIO_O(SYNTH_RATIO_O),
  .OSC_BIAS_LEVEL_O(OSC_BIAS_LEVEL_O), .OSC_BIAS_AT_DEFAULT_O(OSC_BIAS_AT_DEFAULT_O),
  .LANE_PREEMPHASIS_O(LANE_PREEMPHASIS_O), .UI_TICK_I(UI_TICK_I),
  .SER_REINIT_I(SER_REINIT_I), .TIMESTAMP_INPUT_I(TIMESTAMP_INPUT_I),
  .AUX_OUTPUT_PIN_O(AUX_OUTPUT_PIN_O));
